// ---- logic/sysclk_pkg.sv ----
// sysclk_pkg: register map, field positions, reset values, states and carriers
// for the system clock prescaler, oscillator trim and sleep controller.
// assumes a 32-bit AHB-Lite register bus with one 8-bit register per word.
package sysclk_pkg;

	localparam int unsigned CLK_HZ = 10_000_000;

	// register indices; byte address is four times the index
	localparam logic [7:0] DIV_CTRL_IDX   = 8'h61;
	localparam logic [7:0] SLEEP_CTRL_IDX = 8'h53;
	localparam logic [7:0] STATUS_IDX     = 8'h54;
	localparam logic [7:0] TRIM_IDX       = 8'h66;
	localparam int unsigned IDX_W         = 8;

	// clock_divider_control fields
	localparam int unsigned UNLOCK_BIT   = 7;
	localparam int unsigned SEL_W        = 4;
	localparam logic [3:0]  DIV_SEL_MAX  = 4'h8;
	localparam logic [3:0]  DIV_SEL_RST  = 4'h0;
	localparam logic [6:0]  UNLOCK_REST  = 7'h00;
	localparam logic [2:0]  UNLOCK_WIN_CYC = 3'h4;

	// oscillator_trim fields
	localparam int unsigned TRIM_RANGE_BIT = 7;
	localparam logic [7:0]  TRIM_RST       = 8'h00;

	// sleep_control_register fields
	localparam int unsigned SLEEP_ALLOW_BIT = 0;
	localparam int unsigned MODE_LSB        = 1;
	localparam int unsigned BOD_OFF_BIT     = 4;
	localparam logic [7:0]  SLEEP_CTRL_MASK = 8'h1F;
	localparam logic [7:0]  SLEEP_CTRL_RST  = 8'h00;

	// stall after the oscillator start-up before the handler runs
	localparam logic [2:0] WAKE_HALT_CYC = 3'h4;

	typedef logic [2:0] sleep_mode_t;
	localparam sleep_mode_t MODE_IDLE        = 3'b000;
	localparam sleep_mode_t MODE_NOISE_RED   = 3'b001;
	localparam sleep_mode_t MODE_PWR_DOWN    = 3'b010;
	localparam sleep_mode_t MODE_PWR_SAVE    = 3'b011;
	localparam sleep_mode_t MODE_STANDBY     = 3'b110;
	localparam sleep_mode_t MODE_EXT_STANDBY = 3'b111;

	typedef enum logic [3:0]
	{
		ST_RUN   = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_START = 4'b0100,
		ST_HALT  = 4'b1000
	} pwr_state_t;

	typedef struct packed
	{
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic asy;
		logic main_osc;
		logic timer_osc;
	} clk_gate_t;

	typedef struct packed
	{
		logic ext_pin;
		logic twi_match;
		logic async_capable_timer;
		logic mem_ready;
		logic converter;
		logic watchdog;
		logic other_io;
	} wake_src_t;

endpackage

// ---- logic/clk_divider.sv ----
// clk_divider: power-of-two prescaler giving a one-cycle system clock enable.
// assumes the selection is already limited to legal values by its owner.
`timescale 1ns/100ps
module clk_divider
#(
	parameter int unsigned SEL_W = 4,
	parameter int unsigned CNT_W = 8
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// selection and enable
	input  wire logic [SEL_W-1:0] sel,
	output logic                  tick
);

	if (CNT_W < 1 || CNT_W > 16)
		$error("clk_divider: CNT_W out of range");

	logic [CNT_W-1:0] cnt_ff;
	logic [SEL_W-1:0] cur_ff;
	logic             tick_ff;

	function automatic logic [CNT_W-1:0] div_mask(input logic [SEL_W-1:0] s);
		logic [CNT_W:0] one_hot;
		one_hot  = '0;
		one_hot  = (CNT_W+1)'(1) << s;
		div_mask = CNT_W'(one_hot - (CNT_W+1)'(1));
	endfunction

	wire period_end = (cnt_ff == div_mask(cur_ff));

	// the old period runs to its end before the new factor is taken
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff  <= '0;
			cur_ff  <= '0;
			tick_ff <= 1'b0;
		end
		else
		begin
			cnt_ff  <= period_end ? '0 : cnt_ff + CNT_W'(1);
			cur_ff  <= period_end ? sel : cur_ff;
			tick_ff <= period_end;
		end
	end

	assign tick = tick_ff;

endmodule

// ---- logic/sleep_mode_decode.sv ----
// sleep_mode_decode: per sleep mode, the clock domains kept running, the
// wake sources honoured and whether the brown-out detector may be dropped.
// assumes mode codes as in sysclk_pkg; purely combinational.
`timescale 1ns/100ps
module sleep_mode_decode
(
	// mode and context
	input  wire sysclk_pkg::sleep_mode_t mode,
	input  wire logic                    async_capable_timer_async,
	input  wire sysclk_pkg::wake_src_t   src,
	// decoded
	output logic                         mode_valid,
	output sysclk_pkg::clk_gate_t        gates,
	output logic                         wake,
	output logic                         bod_may_drop
);

	function automatic logic is_mode(input logic [2:0] m, input logic [2:0] c);
		is_mode = (m == c);
	endfunction

	wire m_idle = is_mode(mode, sysclk_pkg::MODE_IDLE);
	wire m_nr   = is_mode(mode, sysclk_pkg::MODE_NOISE_RED);
	wire m_pd   = is_mode(mode, sysclk_pkg::MODE_PWR_DOWN);
	wire m_ps   = is_mode(mode, sysclk_pkg::MODE_PWR_SAVE);
	wire m_sb   = is_mode(mode, sysclk_pkg::MODE_STANDBY);
	wire m_es   = is_mode(mode, sysclk_pkg::MODE_EXT_STANDBY);

	assign mode_valid = m_idle | m_nr | m_pd | m_ps | m_sb | m_es;

	// core and flash always stop; the rest per mode
	assign gates.cpu       = 1'b0;
	assign gates.flash     = 1'b0;
	assign gates.io        = m_idle;
	assign gates.adc       = m_idle | m_nr;
	assign gates.asy       = m_idle | m_nr | m_ps | (m_es & async_capable_timer_async);
	assign gates.main_osc  = m_idle | m_nr | m_sb | m_es;
	assign gates.timer_osc = async_capable_timer_async & (m_idle | m_nr | m_ps | m_es);

	// wake sources per mode
	wire t2_ok = m_idle | m_ps | m_es | (m_nr & async_capable_timer_async);
	assign wake = src.ext_pin | src.twi_match | src.watchdog
		| (src.async_capable_timer & t2_ok)
		| ((src.mem_ready | src.converter) & (m_idle | m_nr))
		| (src.other_io & m_idle);

	assign bod_may_drop = m_pd | m_ps | m_sb | m_es;

endmodule

// ---- logic/sysclk_prescale_sleep_ctrl.sv ----
// sysclk_prescale_sleep_ctrl: protected system clock prescaler, RC oscillator
// trim and sleep / wake sequencing, with an AHB-Lite register slave.
// assumes the core raises sleep_instr for one cycle per sleep instruction and
// that wake sources are synchronous levels or pulses on clk.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
module sysclk_prescale_sleep_ctrl
#(
	parameter int unsigned STARTUP_CYCLES = 16,
	parameter int unsigned DIV_CNT_W      = 8
)
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// ahb-lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic [31:0]                hrdata,
	output logic                       hresp,
	// core side
	input  wire logic                  sleep_instr,
	input  wire sysclk_pkg::wake_src_t wake_src,
	input  wire logic                  async_capable_timer_async,
	input  wire logic                  brownout_enable,
	input  wire logic [7:0]            factory_trim,
	// clock system
	output logic                       sys_clk_en,
	output sysclk_pkg::clk_gate_t      clk_gate,
	output logic [7:0]                 trim_value,
	output logic                       trim_range_bit,
	output logic                       brownout_active,
	output logic                       core_halt,
	output logic                       handler_go,
	output logic                       asleep
);

	if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535)
		$error("sysclk_prescale_sleep_ctrl: STARTUP_CYCLES out of range");
	if (DIV_CNT_W < 8)
		$error("sysclk_prescale_sleep_ctrl: DIV_CNT_W too small for divide by 256");

	localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: zero wait states, always OKAY

	logic                                hreadyout_ff;
	logic [31:0]                         hrdata_ff;
	logic                                wr_pend_ff;
	logic [sysclk_pkg::IDX_W-1:0]        wr_idx_ff;
	logic                                wr_map_ff;

	wire addr_phase = hsel & hready & htrans[1];
	wire in_map     = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'b00);
	wire [sysclk_pkg::IDX_W-1:0] addr_idx = haddr[9:2];
	wire [7:0] wd   = hwdata[7:0];
	wire wr_act     = wr_pend_ff & wr_map_ff;

	wire div_wr   = wr_act & (wr_idx_ff == sysclk_pkg::DIV_CTRL_IDX);
	wire trim_wr  = wr_act & (wr_idx_ff == sysclk_pkg::TRIM_IDX);
	wire sleep_wr = wr_act & (wr_idx_ff == sysclk_pkg::SLEEP_CTRL_IDX);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff  <= '0;
			wr_map_ff  <= 1'b0;
		end
		else
		begin
			wr_pend_ff <= addr_phase & hwrite;
			wr_idx_ff  <= addr_phase ? addr_idx : wr_idx_ff;
			wr_map_ff  <= addr_phase & in_map;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// divider unlock window and selection

	logic                              unlock_ff;
	logic [2:0]                        win_ff;
	logic [sysclk_pkg::SEL_W-1:0]      sel_ff;
	logic                              nxt_unlock;
	logic [2:0]                        nxt_win;
	logic [sysclk_pkg::SEL_W-1:0]      nxt_sel;

	// only a write with every other bit zero may set the unlock bit
	wire unlock_req = div_wr & wd[sysclk_pkg::UNLOCK_BIT]
		& (wd[6:0] == sysclk_pkg::UNLOCK_REST);
	// selection is taken only inside the window with unlock written zero
	wire sel_wr     = div_wr & ~wd[sysclk_pkg::UNLOCK_BIT] & unlock_ff;
	wire sel_legal  = (wd[3:0] <= sysclk_pkg::DIV_SEL_MAX);
	wire win_last   = (win_ff == sysclk_pkg::UNLOCK_WIN_CYC - 3'h1);

	always_comb
	begin
		nxt_unlock = unlock_ff;
		nxt_win    = win_ff;
		nxt_sel    = sel_ff;
		if (unlock_ff)
		begin
			nxt_win = win_ff + 3'h1;
			if (win_last)
				nxt_unlock = 1'b0;
		end
		if (sel_wr)
		begin
			nxt_unlock = 1'b0;
			if (sel_legal)
				nxt_sel = wd[3:0];
		end
		else if (unlock_req && !unlock_ff)
		begin
			nxt_unlock = 1'b1;
			nxt_win    = 3'h0;
		end
		// a second unlock inside the window falls through untouched
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			unlock_ff <= 1'b0;
			win_ff    <= 3'h0;
			sel_ff    <= sysclk_pkg::DIV_SEL_RST;
		end
		else
		begin
			unlock_ff <= nxt_unlock;
			win_ff    <= nxt_win;
			sel_ff    <= nxt_sel;
		end
	end

	// the running period finishes on the old factor before the new one applies
	clk_divider
	#(
		.SEL_W (sysclk_pkg::SEL_W),
		.CNT_W (DIV_CNT_W)
	)
	u_div
	(
		.clk   (clk),
		.rst_n (rst_n),
		.sel   (sel_ff),
		.tick  (sys_clk_en)
	);

	////////////////////////////////////////////////////////////////////////////
	// oscillator trim

	logic [7:0] trim_ff;
	logic       trim_loaded_ff;
	logic [7:0] nxt_trim;

	// an async reset may only load constants, so the factory value is caught
	// on the first edge after release; a software write there still wins
	always_comb
	begin
		nxt_trim = trim_ff;
		if (!trim_loaded_ff)
			nxt_trim = factory_trim;
		if (trim_wr)
			nxt_trim = wd;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trim_ff        <= sysclk_pkg::TRIM_RST;
			trim_loaded_ff <= 1'b0;
		end
		else
		begin
			trim_ff        <= nxt_trim;
			trim_loaded_ff <= 1'b1;
		end
	end

	// range bit and fine field go to the oscillator unchanged
	assign trim_value     = trim_ff;
	assign trim_range_bit = trim_ff[sysclk_pkg::TRIM_RANGE_BIT];

	////////////////////////////////////////////////////////////////////////////
	// sleep control and power state

	logic [7:0]                 sleep_ctrl_ff;
	logic [7:0]                 nxt_sleep_ctrl;
	sysclk_pkg::pwr_state_t     state_ff;
	sysclk_pkg::pwr_state_t     nxt_state;
	sysclk_pkg::sleep_mode_t    mode_ff;
	logic [15:0]                cnt_ff;
	logic [15:0]                nxt_cnt;

	assign nxt_sleep_ctrl = sleep_wr ? (wd & sysclk_pkg::SLEEP_CTRL_MASK) : sleep_ctrl_ff;

	wire sleep_allow = sleep_ctrl_ff[sysclk_pkg::SLEEP_ALLOW_BIT];
	wire bod_off_req = sleep_ctrl_ff[sysclk_pkg::BOD_OFF_BIT];
	wire [2:0] sel_mode = sleep_ctrl_ff[sysclk_pkg::MODE_LSB +: 3];

	logic                  req_valid;
	logic                  cur_valid;
	sysclk_pkg::clk_gate_t mode_gates;
	logic                  wake_hit;
	logic                  bod_may_drop;

	// the requested code is checked before entry; the latched one while asleep
	sleep_mode_decode u_req
	(
		.mode         (sel_mode),
		.async_capable_timer_async (async_capable_timer_async),
		.src          (wake_src),
		.mode_valid   (req_valid),
		.gates        (),
		.wake         (),
		.bod_may_drop ()
	);

	wire enter_sleep = sleep_instr & sleep_allow & req_valid;
	// decode the mode that holds after this edge so gates and brown-out switch on entry
	wire [2:0] nxt_mode = (enter_sleep && state_ff == sysclk_pkg::ST_RUN) ? sel_mode : mode_ff;

	sleep_mode_decode u_cur
	(
		.mode         (nxt_mode),
		.async_capable_timer_async (async_capable_timer_async),
		.src          (wake_src),
		.mode_valid   (cur_valid),
		.gates        (mode_gates),
		.wake         (wake_hit),
		.bod_may_drop (bod_may_drop)
	);

	wire cnt_zero    = (cnt_ff == 16'h0);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			sysclk_pkg::ST_RUN:
			begin
				if (enter_sleep)
					nxt_state = sysclk_pkg::ST_SLEEP;
			end
			sysclk_pkg::ST_SLEEP:
			begin
				if (wake_hit && cur_valid)
				begin
					nxt_state = sysclk_pkg::ST_START;
					nxt_cnt   = STARTUP_LAST;
				end
			end
			sysclk_pkg::ST_START:
			begin
				if (cnt_zero)
				begin
					nxt_state = sysclk_pkg::ST_HALT;
					nxt_cnt   = {13'h0, sysclk_pkg::WAKE_HALT_CYC - 3'h1};
				end
				else
					nxt_cnt = cnt_ff - 16'h1;
			end
			sysclk_pkg::ST_HALT:
			begin
				if (cnt_zero)
					nxt_state = sysclk_pkg::ST_RUN;
				else
					nxt_cnt = cnt_ff - 16'h1;
			end
			default:
			begin
				nxt_state = sysclk_pkg::ST_RUN;
				nxt_cnt   = 16'h0;
			end
		endcase
	end

	// gates follow the next state so they change on the same edge as the state
	sysclk_pkg::clk_gate_t run_gates;
	sysclk_pkg::clk_gate_t start_gates;
	sysclk_pkg::clk_gate_t nxt_gate;

	assign run_gates   = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1,
		main_osc: 1'b1, timer_osc: async_capable_timer_async};
	assign start_gates = '{cpu: 1'b0, flash: 1'b0, io: mode_gates.io,
		adc: mode_gates.adc, asy: mode_gates.asy, main_osc: 1'b1,
		timer_osc: mode_gates.timer_osc};

	wire nxt_asleep = (nxt_state == sysclk_pkg::ST_SLEEP);
	wire nxt_start  = (nxt_state == sysclk_pkg::ST_START);

	assign nxt_gate = nxt_asleep ? mode_gates
		: nxt_start ? start_gates : run_gates;

	// brown-out may only drop where the mode allows it
	wire nxt_bod = brownout_enable & ~(nxt_asleep & bod_off_req & bod_may_drop);

	logic                  core_halt_ff;
	logic                  handler_go_ff;
	logic                  asleep_ff;
	logic                  bod_ff;
	sysclk_pkg::clk_gate_t gate_ff;

	// mode is latched at entry so a later register write cannot change the
	// wake set or gating of a sleep already in progress
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// reset leaves any sleep and restarts at the vector
			state_ff      <= sysclk_pkg::ST_RUN;
			cnt_ff        <= 16'h0;
			mode_ff       <= sysclk_pkg::MODE_IDLE;
			sleep_ctrl_ff <= sysclk_pkg::SLEEP_CTRL_RST;
			core_halt_ff  <= 1'b0;
			handler_go_ff <= 1'b0;
			asleep_ff     <= 1'b0;
			bod_ff        <= 1'b0;
			gate_ff       <= '0;
		end
		else
		begin
			state_ff      <= nxt_state;
			cnt_ff        <= nxt_cnt;
			mode_ff       <= nxt_mode;
			sleep_ctrl_ff <= nxt_sleep_ctrl;
			core_halt_ff  <= (nxt_state != sysclk_pkg::ST_RUN);
			// handler starts and resumes after the sleep instruction
			handler_go_ff <= (state_ff == sysclk_pkg::ST_HALT) & cnt_zero;
			asleep_ff     <= nxt_asleep;
			bod_ff        <= nxt_bod;
			gate_ff       <= nxt_gate;
		end
	end

	// nothing here touches core registers or data memory on wake
	assign core_halt       = core_halt_ff;
	assign handler_go      = handler_go_ff;
	assign asleep          = asleep_ff;
	assign brownout_active = bod_ff;
	assign clk_gate        = gate_ff;

	////////////////////////////////////////////////////////////////////////////
	// read data: taken from next values so a read right behind a write sees it

	wire [7:0] div_view    = {nxt_unlock, 3'b000, nxt_sel};
	wire [7:0] status_view = {1'b0, nxt_asleep, nxt_start, nxt_unlock,
		nxt_state == sysclk_pkg::ST_RUN, nxt_state == sysclk_pkg::ST_HALT,
		(nxt_state == sysclk_pkg::ST_HALT) | nxt_start, nxt_bod};

	wire [7:0] rd_byte =
		(addr_idx == sysclk_pkg::DIV_CTRL_IDX)   ? div_view :
		(addr_idx == sysclk_pkg::TRIM_IDX)       ? nxt_trim :
		(addr_idx == sysclk_pkg::SLEEP_CTRL_IDX) ? nxt_sleep_ctrl :
		(addr_idx == sysclk_pkg::STATUS_IDX)     ? status_view : 8'h00;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hreadyout_ff <= 1'b1;
			hrdata_ff    <= 32'h0000_0000;
		end
		else
		begin
			hreadyout_ff <= 1'b1;
			if (addr_phase && !hwrite)
				hrdata_ff <= {24'h00_0000, in_map ? rd_byte : 8'h00};
		end
	end

	assign hreadyout = hreadyout_ff;
	assign hrdata    = hrdata_ff;
	assign hresp     = 1'b0;

endmodule

// ---- tb/sysclk_props_properties.sv ----
// sysclk_props: port-level properties of the trim, sleep and wake logic.
// assumes it is bound into sysclk_prescale_sleep_ctrl; one clock domain.
`timescale 1ns/100ps
module sysclk_props
#(
	parameter int unsigned STARTUP_CYCLES = 16
)
(
	// clock and reset
	input wire logic                  clk,
	input wire logic                  rst_n,
	// watched ports
	input wire logic                  sleep_instr,
	input wire sysclk_pkg::wake_src_t wake_src,
	input wire logic                  brownout_enable,
	input wire logic [7:0]            trim_value,
	input wire logic                  trim_range_bit,
	input wire sysclk_pkg::clk_gate_t clk_gate,
	input wire logic                  brownout_active,
	input wire logic                  core_halt,
	input wire logic                  handler_go,
	input wire logic                  asleep
);
	localparam int WAKE_D = STARTUP_CYCLES + 4;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	sequence s_leave; $fell(asleep); endsequence
	// start-up plus stall is never shorter than five samples of halt
	sequence s_hold; core_halt [*5]; endsequence
	property p_range; trim_range_bit == trim_value[7]; endproperty
	a_range: assert property (p_range) else $error("range bit differs");
	property p_gated; asleep |-> !clk_gate.cpu && !clk_gate.flash; endproperty
	a_gated: assert property (p_gated) else $error("core clock runs asleep");
	property p_entry; $rose(asleep) |-> $past(sleep_instr); endproperty
	a_entry: assert property (p_entry) else $error("sleep without instruction");
	property p_wake; s_leave |-> ##WAKE_D handler_go; endproperty
	a_wake: assert property (p_wake) else $error("handler start mistimed");
	property p_halt; s_leave |-> s_hold; endproperty
	a_halt: assert property (p_halt) else $error("core released early");
	property p_go; handler_go |-> !core_halt && $past(core_halt); endproperty
	a_go: assert property (p_go) else $error("handler start out of halt");
	property p_wdt; asleep && wake_src.watchdog |=> !asleep; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog did not wake");
	property p_io; asleep && !clk_gate.io && wake_src == 7'h01 |=> asleep; endproperty
	a_io: assert property (p_io) else $error("other io woke deep sleep");
	property p_bod; asleep && clk_gate.adc && brownout_enable |-> brownout_active; endproperty
	a_bod: assert property (p_bod) else $error("brown-out dropped in light sleep");
endmodule
bind sysclk_prescale_sleep_ctrl sysclk_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_sysclk_props
(
	.clk(clk), .rst_n(rst_n), .sleep_instr(sleep_instr), .wake_src(wake_src),
	.brownout_enable(brownout_enable), .trim_value(trim_value),
	.trim_range_bit(trim_range_bit), .clk_gate(clk_gate),
	.brownout_active(brownout_active), .core_halt(core_halt),
	.handler_go(handler_go), .asleep(asleep)
);

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the prescaler, oscillator trim and sleep control.
// assumes the property checker is bound on its own; drives the ahb-lite port directly.
`timescale 1ns/100ps
`define CHK(nm, e, a) chk(nm, 32'(e), 32'(a))
module tb_top;
	localparam logic [31:0] A_DIV = 32'({sysclk_pkg::DIV_CTRL_IDX, 2'h0});
	localparam logic [31:0] A_SLP = 32'({sysclk_pkg::SLEEP_CTRL_IDX, 2'h0});
	localparam logic [31:0] A_TRM = 32'({sysclk_pkg::TRIM_IDX, 2'h0});
	logic                  clk, rst_n, hsel, hwrite, hreadyout, hresp, sleep_instr;
	logic                  async_capable_timer_async, brownout_enable, sys_clk_en, trim_range_bit;
	logic                  brownout_active, core_halt, handler_go, asleep;
	logic [1:0]            htrans;
	logic [2:0]            hsize;
	logic [31:0]           haddr, hwdata, hrdata, rd;
	logic [7:0]            factory_trim, trim_value, v;
	sysclk_pkg::wake_src_t wake_src;
	sysclk_pkg::clk_gate_t clk_gate;
	int                    fails, n_compared, seed, m_sel, c;
	int                    modes[$] = '{0, 1, 2, 3, 6, 7};
	localparam int STARTUP = 2;
	sysclk_prescale_sleep_ctrl #(.STARTUP_CYCLES(STARTUP), .DIV_CNT_W(8))
		i_sysclk_prescale_sleep_ctrl
	(
		.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sleep_instr(sleep_instr),
		.wake_src(wake_src), .async_capable_timer_async(async_capable_timer_async), .brownout_enable(brownout_enable),
		.factory_trim(factory_trim), .sys_clk_en(sys_clk_en), .clk_gate(clk_gate),
		.trim_value(trim_value), .trim_range_bit(trim_range_bit),
		.brownout_active(brownout_active), .core_halt(core_halt),
		.handler_go(handler_go), .asleep(asleep)
	);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
		n_compared++;
		if (a !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, a);
		end
	endtask
	task stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// entered just after a rising edge; returns on the edge that ends the data phase
	task xfer(input logic w, input logic [31:0] ad, input logic [7:0] d);
		hsel   <= 1'b1;
		haddr  <= ad;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task do_reset(input int n);
		rst_n        <= 1'b0;
		factory_trim <= 8'($random(seed));
		m_sel = 0;
		repeat (n) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		`CHK("trim reset", factory_trim, trim_value);
		`CHK("awake", 0, {asleep, core_halt});
		@(posedge clk);
	endtask
	task pulse_sleep();
		sleep_instr <= 1'b1;
		@(posedge clk);
		sleep_instr <= 1'b0;
		@(negedge clk);
	endtask
	// second write lands gap plus two cycles after the first; nothing intervenes
	task automatic div_try(input logic [7:0] f, input int gap, input logic [7:0] d, input int ok);
		int g;
		xfer(1'b1, A_DIV, f);
		repeat (gap) @(posedge clk);
		xfer(1'b1, A_DIV, d);
		if (ok)
			m_sel = d;
		xfer(1'b0, A_DIV, 8'h00);
		`CHK("divider reg", m_sel, rd);
		// pulses are a single cycle, so sampling on the falling edge counts each once
		repeat (2) do @(negedge clk); while (sys_clk_en !== 1'b1);
		g = 0;
		do
		begin
			@(negedge clk);
			g++;
		end
		while (sys_clk_en !== 1'b1 && g < 300);
		@(posedge clk);
		`CHK("divider gap", 1 << m_sel, g);
	endtask
	function automatic sysclk_pkg::clk_gate_t eg(input int m, input logic t);
		case (m)
			0: return {6'h0F, t};
			1: return {6'h07, t};
			3: return {6'h02, t};
			6: return 7'h02;
			7: return {4'h0, t, 1'b1, t};
			default: return 7'h00;
		endcase
	endfunction
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'hd878;
		{rst_n, hsel, hwrite, sleep_instr, async_capable_timer_async} = '0;
		{htrans, haddr, hwdata, factory_trim, wake_src} = '0;
		hsize = 3'h2;
		brownout_enable = 1'b1;
		do_reset(16);
		div_try(8'h80, 0, 8'h03, 1);
		div_try(8'h80, 1, 8'h08, 1);
		div_try(8'h80, 0, 8'h09, 0);
		div_try(8'h81, 0, 8'h01, 0);
		div_try(8'h80, 6, 8'h01, 0);
		xfer(1'b1, A_DIV, 8'h80);
		@(posedge clk);
		div_try(8'h80, 0, 8'h02, 0);
		div_try(8'h80, 0, 8'h00, 1);
		// no memory writes run in this bench, so any trim value is allowed
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($random(seed));
			xfer(1'b1, A_TRM, v);
			xfer(1'b0, A_TRM, 8'h00);
			`CHK("trim reg", v, rd);
			@(negedge clk);
			`CHK("trim range", v[7], trim_range_bit);
			`CHK("trim out", v, trim_value);
			@(posedge clk);
		end
		xfer(1'b1, 32'h3FC, 8'hFF);
		xfer(1'b0, 32'h3FC, 8'h00);
		`CHK("unmapped", 0, rd);
		`CHK("unmapped resp", 0, hresp);
		// standby is entered as if a crystal were the main source
		foreach (modes[i])
		begin
			async_capable_timer_async <= 1'($random(seed));
			v = 8'h11 | 8'(modes[i] << 1);
			xfer(1'b1, A_SLP, v);
			xfer(1'b0, A_SLP, 8'h00);
			`CHK("sleep reg", v, rd);
			pulse_sleep();
			`CHK("asleep", 1, asleep);
			`CHK("gates", eg(modes[i], async_capable_timer_async), clk_gate);
			`CHK("brown-out", modes[i] < 2, brownout_active);
			@(posedge clk);
			wake_src <= 7'h01;
			repeat (2) @(posedge clk);
			@(negedge clk);
			`CHK("other io wake", modes[i] == 0, !asleep);
			@(posedge clk);
			wake_src <= 7'h02;
			c = 0;
			do
			begin
				@(negedge clk);
				c++;
			end
			while (handler_go !== 1'b1 && c < 60);
			`CHK("handler go", 1, handler_go);
			`CHK("wake delay", modes[i] ? STARTUP + 6 : STARTUP + 3, c);
			`CHK("run gates", {6'h3F, async_capable_timer_async}, clk_gate);
			`CHK("halt off", 0, core_halt);
			@(posedge clk);
			wake_src <= 7'h00;
		end
		for (int i = 0; i < 2; i++)
		begin
			xfer(1'b1, A_SLP, i ? 8'h04 : 8'h09);
			pulse_sleep();
			`CHK("refused sleep", 0, asleep);
			@(posedge clk);
		end
		brownout_enable <= 1'b0;
		xfer(1'b1, A_SLP, 8'h05);
		pulse_sleep();
		`CHK("asleep pd", 1, asleep);
		`CHK("brown-out off", 0, brownout_active);
		@(posedge clk);
		do_reset(3);
		stop_test();
	end
endmodule
